// ==== dv/ext_pin_interrupts_test.sv ====
// Self-checking bench for the pin interrupt block: APB registers and pin scenarios
`timescale 1ns/1ps
module ext_pin_interrupts_test;
  import ext_int_pkg::*;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 5;
  int cycles = 0;
  int k;
  int j;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata, rdata, d;
  logic pready, pslverr, serr, first_n, second_n, pc0_pu;
  logic [2:0] fetch = 3'b000;
  logic [2:0] irq;
  logic [1:0] gen_low = 2'b00;
  logic [KEY_PINS-1:0] keys = 8'h00;
  logic [KEY_PINS-1:0] key_pu, key_pins_n;
  logic [15:0] key_vec;
  always #4 clk = ~clk;
  // Whole run needs well under a thousand cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  ext_pin_interrupts ext_pin_interrupts_i (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIRST_EXT_INT_PIN_N(first_n),
    .SECOND_EXT_INT_PIN_N(second_n), .KEY_PINS_N(key_pins_n), .FIRST_VEC_FETCH(fetch[0]),
    .SECOND_VEC_FETCH(fetch[1]), .KEY_VEC_FETCH(fetch[2]), .FIRST_IRQ(irq[0]),
    .SECOND_IRQ(irq[1]), .KEY_IRQ(irq[2]), .KEY_VECTOR(key_vec),
    .PORT_C_BIT0_PULLUP_EN(pc0_pu), .KEY_PULLUP_EN(key_pu));
  pin_source_model pin_source_model_i (.clk(clk), .gen_low(gen_low), .press(keys),
    .pullup_en(key_pu), .first_pin_n(first_n), .second_pin_n(second_n),
    .key_pins_n(key_pins_n));
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0);
    check(rdata, exp, what);
    check(serr, 1'b0, "slave error on mapped read");
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic pulse(input int n);
    @(posedge clk);
    fetch[n] <= 1'b1;
    @(posedge clk);
    fetch[n] <= 1'b0;
    settle();
  endtask : pulse
  task automatic gen_set(input int n, input logic v);
    @(posedge clk);
    gen_low[n] <= v;
    settle();
  endtask : gen_set
  task automatic key_set(input logic [7:0] v);
    @(posedge clk);
    keys <= v;
    settle();
  endtask : key_set
  // Enabling a pin lets its stale sampled level count as a fall, so clear afterwards
  task automatic key_cfg(input logic [7:0] en, input logic [31:0] ctrl);
    wr(KEY_PIN_ENABLES_ADDR, {24'h0, en});
    settle();
    wr(KEY_STATUS_CONTROL_ADDR, ctrl | 32'h4);
    settle();
  endtask : key_cfg
  function automatic logic [31:0] ctrl_view(input logic [31:0] v, input logic second);
    return v & (second ? 32'h43 : 32'h03);
  endfunction : ctrl_view
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    check(pc0_pu, 1'b1, "port c pull-up at reset");
    check(key_pu, 8'h00, "key pull-ups at reset");
    check(irq, 3'b000, "requests at reset");
    rd(EXT_INT_B_STATUS_CONTROL_ADDR, 32'h0, "second ctrl reset");
    rd(FIRST_CTRL_ADDR, 32'h0, "first ctrl reset");
    apb(1'b0, 8'h30, 32'h0);
    check(serr, 1'b1, "unmapped error");
    check(rdata, 32'h0, "unmapped data");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(EXT_INT_B_STATUS_CONTROL_ADDR, d);
      rd(EXT_INT_B_STATUS_CONTROL_ADDR, ctrl_view(d, 1'b1), "second ctrl");
      check(pc0_pu, {31'h0, ~d[6]}, "port c pull-up");
      wr(FIRST_CTRL_ADDR, d);
      rd(FIRST_CTRL_ADDR, ctrl_view(d, 1'b0), "first ctrl");
      wr(KEY_PIN_ENABLES_ADDR, d);
      rd(KEY_PIN_ENABLES_ADDR, d & 32'hFF, "key enables");
      check(key_pu, d[7:0], "key pull-ups follow enables");
    end
    for (int p = 0; p < 2; p++) begin
      a = p ? EXT_INT_B_STATUS_CONTROL_ADDR : FIRST_CTRL_ADDR;
      wr(a, 32'h0);
      gen_set(p, 1'b1);
      rd(a, 32'h8, "edge request pending");
      check(irq[p], 1'b1, "edge request raised");
      wr(a, 32'h4);
      rd(a, 32'h0, "ack clears while low in edge mode");
      wr(a, 32'h1);
      settle();
      rd(a, 32'h9, "low level request");
      pulse(p);
      rd(a, 32'h9, "level request held while low");
      wr(a, 32'h3);
      settle();
      check(irq[p], 1'b0, "masked request");
      rd(a, 32'hB, "masked request still pending");
      gen_set(p, 1'b0);
      wr(a, 32'h7);
      rd(a, 32'h3, "ack after release");
      wr(a, 32'h0);
      settle();
      check(irq[p], 1'b0, "request gone");
    end
    k = $unsigned($random(seed)) % 8;
    j = (k + 3) % 8;
    key_cfg(8'hFF, 32'h0);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h0, "key idle");
    key_set(8'h01 << k);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h8, "key request");
    check(key_vec, KEY_VECTOR_ADDR, "key vector");
    wr(KEY_STATUS_CONTROL_ADDR, 32'h4);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h0, "software key ack");
    key_set(keys | (8'h01 << j));
    rd(KEY_STATUS_CONTROL_ADDR, 32'h0, "fall while another low");
    key_set(8'h00);
    key_set(8'h01 << j);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h8, "fall after ack");
    pulse(2);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h0, "vector fetch ack");
    key_set(8'h00);
    key_cfg(8'h01 << k, 32'h0);
    key_set(~(8'h01 << k));
    rd(KEY_STATUS_CONTROL_ADDR, 32'h0, "disabled pins ignored");
    key_set(8'h00);
    key_cfg(8'hFF, 32'h1);
    key_set(8'h01 << k);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h9, "key level request");
    wr(KEY_STATUS_CONTROL_ADDR, 32'h5);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h9, "ack while low");
    key_set(8'h00);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h1, "ack then release");
    key_set(8'h01 << j);
    key_set(8'h00);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h9, "release without ack");
    pulse(2);
    rd(KEY_STATUS_CONTROL_ADDR, 32'h1, "release then ack");
    wr(KEY_STATUS_CONTROL_ADDR, 32'h2);
    key_set(8'h01 << k);
    check(irq[2], 1'b0, "key masked");
    check(key_vec, NO_VECTOR, "no vector when masked");
    rd(KEY_STATUS_CONTROL_ADDR, 32'hA, "masked key pending");
    conclude();
  end
endmodule : ext_pin_interrupts_test

// ==== dv/pin_source_model.sv ====
// Pin sources: general interrupt drivers and keyboard switches with pull-up behaviour
`timescale 1ns/1ps
module pin_source_model
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] gen_low,
  input wire logic [KEY_PINS-1:0] press,
  input wire logic [KEY_PINS-1:0] pullup_en,
  output logic first_pin_n,
  output logic second_pin_n,
  output logic [KEY_PINS-1:0] key_pins_n
);
  logic [KEY_PINS-1:0] float_reg = 8'h5A;
  // An open switch without pull-up floats; a toggling level stops it passing as high
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  assign key_pins_n = ~press & (pullup_en | float_reg);
  assign first_pin_n = ~gen_low[0];
  assign second_pin_n = ~gen_low[1];
endmodule : pin_source_model

// ==== inc/ext_int_pkg.sv ====
// Package: register map, field positions and carrier types for the pin interrupt block
package ext_int_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int KEY_PINS = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] FIRST_CTRL_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] EXT_INT_B_STATUS_CONTROL_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] KEY_STATUS_CONTROL_ADDR = 8'h20;
  localparam logic [ADDR_W-1:0] KEY_PIN_ENABLES_ADDR = 8'h24;
  // Field positions of the three status/control registers; PULLUP_DIS_BIT is used by the second only
  localparam int PULLUP_DIS_BIT = 6;
  localparam int PEND_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int MASK_BIT = 1;
  localparam int MODE_BIT = 0;
  // Reset values
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [KEY_PINS-1:0] KEY_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  // Keyboard vector location
  localparam logic [15:0] KEY_VECTOR_ADDR = 16'hFFE0;
  localparam logic [15:0] NO_VECTOR = 16'h0000;
  typedef struct packed {
    logic mask;
    logic mode;
  } sense_ctrl_t;
  localparam sense_ctrl_t SENSE_CTRL_RST = '{mask: CTRL_BIT_RST, mode: CTRL_BIT_RST};
endpackage : ext_int_pkg

// ==== logic/ext_pin_interrupts.sv ====
// External pin interrupts: two general pins and an eight-pin keyboard group behind APB
//
// Contract
// - First pin mask bit set blocks its requests; reset clears mask.
// - First pin sense bit: 1 edge plus low level, 0 edge only.
// - Second pin status/control register at 0x1C, unused bits read zero.
// - Bit 6 set disables the port C bit 0 pull-up; reset keeps it on.
// - Bit 3 is read-only and shows the second pin's pending request.
// - Writing 1 to bit 2 clears second latch; bit reads zero.
// - Bit 1 masks second pin requests; reset clears it.
// - Bit 0 selects second pin edge-and-level when 1, edge-only when 0.
// - Each keyboard pin has its own enable bit.
// - An enabled keyboard pin also has its pull-up switched on.
// - Latch keyboard request when enabled pins go low after all were high.
// - One keyboard sense bit selects edge-only or edge-and-level for all pins.
// - Edge-only: no new request while another enabled pin is low.
// - Edge-and-level: request stays while any enabled pin is low.
// - Edge-and-level: clear needs acknowledge and all enabled pins high.
// - Vector fetch or software acknowledge bit clears the keyboard request.
// - Falling edge after software acknowledge latches a new request.
// - Unmasked keyboard request presents vector location FFE0/FFE1 to the CPU.
// - Acknowledge and pins-high may happen in either order.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module ext_pin_interrupts
  import ext_int_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FIRST_EXT_INT_PIN_N,
  input wire logic SECOND_EXT_INT_PIN_N,
  input wire logic [KEY_PINS-1:0] KEY_PINS_N,
  input wire logic FIRST_VEC_FETCH,
  input wire logic SECOND_VEC_FETCH,
  input wire logic KEY_VEC_FETCH,
  output logic FIRST_IRQ,
  output logic SECOND_IRQ,
  output logic KEY_IRQ,
  output logic [15:0] KEY_VECTOR,
  output logic PORT_C_BIT0_PULLUP_EN,
  output logic [KEY_PINS-1:0] KEY_PULLUP_EN
);
  localparam int SYNC_W = KEY_PINS + 2;

  // Synchroniser; the first stage is read only by the second
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {KEY_PINS_N, SECOND_EXT_INT_PIN_N, FIRST_EXT_INT_PIN_N};
      sync2_reg <= sync1_reg;
    end
  end

  wire logic first_pin_n = sync2_reg[0];
  wire logic second_pin_n = sync2_reg[1];
  wire logic [KEY_PINS-1:0] key_pins_n = sync2_reg[SYNC_W-1:2];

  // Control registers
  sense_ctrl_t first_ctrl_reg;
  sense_ctrl_t second_ctrl_reg;
  sense_ctrl_t key_ctrl_reg;
  logic second_pin_pullup_disable_reg;
  logic [KEY_PINS-1:0] key_pin_enables_reg;

  // APB slave: one wait state, answer in the second access cycle
  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;

  wire logic access = PSEL & PENABLE;
  wire logic first_access = access & ~pready_reg;
  wire logic commit = access & pready_reg;
  wire logic wr_commit = commit & PWRITE;
  wire logic sel_first = PADDR == FIRST_CTRL_ADDR;
  wire logic sel_second = PADDR == EXT_INT_B_STATUS_CONTROL_ADDR;
  wire logic sel_key_sc = PADDR == KEY_STATUS_CONTROL_ADDR;
  wire logic sel_key_en = PADDR == KEY_PIN_ENABLES_ADDR;
  wire logic mapped = sel_first | sel_second | sel_key_sc | sel_key_en;

  wire logic wr_first = wr_commit & sel_first;
  wire logic wr_second = wr_commit & sel_second;
  wire logic wr_key_sc = wr_commit & sel_key_sc;
  wire logic wr_key_en = wr_commit & sel_key_en;
  wire logic wdata_ack = PWDATA[ACK_BIT];

  // Acknowledges from vector fetch or a software write of 1
  wire logic first_ack = FIRST_VEC_FETCH | (wr_first & wdata_ack);
  wire logic second_ack = SECOND_VEC_FETCH | (wr_second & wdata_ack);
  wire logic key_ack = KEY_VEC_FETCH | (wr_key_sc & wdata_ack);

  logic first_pend;
  logic second_pend;
  logic key_pend;

  pin_request_latch u_first (
    .clk(CLK),
    .reset(RESET),
    .pin_n(first_pin_n),
    .mode(first_ctrl_reg.mode),
    .ack(first_ack),
    .pending(first_pend)
  );

  pin_request_latch u_second (
    .clk(CLK),
    .reset(RESET),
    .pin_n(second_pin_n),
    .mode(second_ctrl_reg.mode),
    .ack(second_ack),
    .pending(second_pend)
  );

  key_request_latch u_key (
    .clk(CLK),
    .reset(RESET),
    .pins_n(key_pins_n),
    .enables(key_pin_enables_reg),
    .mode(key_ctrl_reg.mode),
    .ack(key_ack),
    .pending(key_pend)
  );

  // Status/control read images; acknowledge bits always read zero
  logic [DATA_W-1:0] first_image;
  logic [DATA_W-1:0] second_image;
  logic [DATA_W-1:0] key_sc_image;
  logic [DATA_W-1:0] key_en_image;
  logic [DATA_W-1:0] read_mux;

  always_comb begin
    first_image = DATA_ZERO;
    first_image[PEND_BIT] = first_pend;
    first_image[MASK_BIT] = first_ctrl_reg.mask;
    first_image[MODE_BIT] = first_ctrl_reg.mode;
    second_image = DATA_ZERO;
    second_image[PULLUP_DIS_BIT] = second_pin_pullup_disable_reg;
    second_image[PEND_BIT] = second_pend;
    second_image[MASK_BIT] = second_ctrl_reg.mask;
    second_image[MODE_BIT] = second_ctrl_reg.mode;
    key_sc_image = DATA_ZERO;
    key_sc_image[PEND_BIT] = key_pend;
    key_sc_image[MASK_BIT] = key_ctrl_reg.mask;
    key_sc_image[MODE_BIT] = key_ctrl_reg.mode;
    key_en_image = DATA_ZERO;
    key_en_image[KEY_PINS-1:0] = key_pin_enables_reg;
  end

  assign read_mux = sel_first ? first_image :
                    sel_second ? second_image :
                    sel_key_sc ? key_sc_image :
                    sel_key_en ? key_en_image : DATA_ZERO;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= DATA_ZERO;
    end else begin
      pready_reg <= first_access;
      pslverr_reg <= first_access & ~mapped;
      if (first_access) begin
        prdata_reg <= PWRITE ? DATA_ZERO : read_mux;
      end
    end
  end

  // Register writes land only at the edge where PREADY is seen high
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      first_ctrl_reg <= SENSE_CTRL_RST;
      second_ctrl_reg <= SENSE_CTRL_RST;
      key_ctrl_reg <= SENSE_CTRL_RST;
      second_pin_pullup_disable_reg <= CTRL_BIT_RST;
      key_pin_enables_reg <= KEY_EN_RST;
    end else begin
      if (wr_first) begin
        first_ctrl_reg <= '{mask: PWDATA[MASK_BIT], mode: PWDATA[MODE_BIT]};
      end
      if (wr_second) begin
        second_ctrl_reg <= '{mask: PWDATA[MASK_BIT], mode: PWDATA[MODE_BIT]};
        second_pin_pullup_disable_reg <= PWDATA[PULLUP_DIS_BIT];
      end
      if (wr_key_sc) begin
        key_ctrl_reg <= '{mask: PWDATA[MASK_BIT], mode: PWDATA[MODE_BIT]};
      end
      if (wr_key_en) begin
        key_pin_enables_reg <= PWDATA[KEY_PINS-1:0];
      end
    end
  end

  // Outputs toward the CPU and the pad cells
  logic first_irq_reg;
  logic second_irq_reg;
  logic key_irq_reg;
  logic [15:0] key_vector_reg;
  logic portc0_pullup_reg;
  logic [KEY_PINS-1:0] key_pullup_reg;

  wire logic key_irq_next = key_pend & ~key_ctrl_reg.mask;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      first_irq_reg <= 1'b0;
      second_irq_reg <= 1'b0;
      key_irq_reg <= 1'b0;
      key_vector_reg <= NO_VECTOR;
      portc0_pullup_reg <= 1'b1;
      key_pullup_reg <= KEY_EN_RST;
    end else begin
      first_irq_reg <= first_pend & ~first_ctrl_reg.mask;
      second_irq_reg <= second_pend & ~second_ctrl_reg.mask;
      key_irq_reg <= key_irq_next;
      key_vector_reg <= key_irq_next ? KEY_VECTOR_ADDR : NO_VECTOR;
      portc0_pullup_reg <= ~second_pin_pullup_disable_reg;
      key_pullup_reg <= key_pin_enables_reg;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign FIRST_IRQ = first_irq_reg;
  assign SECOND_IRQ = second_irq_reg;
  assign KEY_IRQ = key_irq_reg;
  assign KEY_VECTOR = key_vector_reg;
  assign PORT_C_BIT0_PULLUP_EN = portc0_pullup_reg;
  assign KEY_PULLUP_EN = key_pullup_reg;

  // Checks
  wire logic key_low = |(~key_pins_n & key_pin_enables_reg);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence first_masked_s;
    first_ctrl_reg.mask;
  endsequence

  sequence key_ack_while_low_s;
    key_pend && key_ctrl_reg.mode && key_ack && key_low;
  endsequence

  sequence key_ack_while_high_s;
    key_pend && key_ctrl_reg.mode && key_ack && !key_low;
  endsequence

  first_mask_blocks_a: assert property (first_masked_s |=> !FIRST_IRQ)
    else $error("first pin request passed its mask");

  first_level_holds_a: assert property (
    first_ctrl_reg.mode && !first_pin_n |=> first_pend)
    else $error("first pin low level did not hold request");

  second_reserved_zero_a: assert property (
    PREADY && !PWRITE && !PSLVERR && sel_second |->
    PRDATA[31:7] == 25'h0 && PRDATA[5:4] == 2'h0 && !PRDATA[ACK_BIT])
    else $error("reserved or ack bits of second register read nonzero");

  pullup_disable_a: assert property (
    wr_second && PWDATA[PULLUP_DIS_BIT] |=> ##1 !PORT_C_BIT0_PULLUP_EN)
    else $error("port C bit 0 pull-up not disabled");

  pending_readback_a: assert property (
    PREADY && !PWRITE && sel_second |-> PRDATA[PEND_BIT] == $past(second_pend))
    else $error("second pending flag read wrong");

  second_ack_clears_a: assert property (
    second_ack && !second_ctrl_reg.mode && second_pin_n |=> !second_pend)
    else $error("second acknowledge failed to clear the latch");

  second_mask_gate_a: assert property (
    second_pend && !second_ctrl_reg.mask |=> SECOND_IRQ)
    else $error("unmasked second request not raised");

  key_edge_blocked_a: assert property (
    !key_ctrl_reg.mode && !key_pend && key_low && $past(key_low) |=> !key_pend)
    else $error("keyboard edge latched while another pin low");

  key_level_holds_a: assert property (
    key_ctrl_reg.mode && key_low |=> key_pend)
    else $error("keyboard level request dropped while pin low");

  key_ack_early_a: assert property (key_ack_while_low_s |=> key_pend)
    else $error("keyboard request cleared while pins still low");

  key_ack_late_a: assert property (key_ack_while_high_s |=> !key_pend)
    else $error("keyboard request stayed after ack with pins high");

  key_vector_out_a: assert property (
    key_pend && !key_ctrl_reg.mask |=> KEY_IRQ && KEY_VECTOR == KEY_VECTOR_ADDR)
    else $error("keyboard vector not presented");

  key_pullup_follow_a: assert property (
    wr_key_en |=> ##1 KEY_PULLUP_EN == $past(PWDATA[KEY_PINS-1:0], 2))
    else $error("keyboard pull-ups do not follow enables");

  apb_answer_a: assert property (first_access |=> PREADY ##1 !PREADY)
    else $error("APB answer not exactly one cycle after access start");

  // Fall of the combined enabled-pin level; an acknowledge in that cycle must not hide it
  sequence key_fall_s;
    $rose(key_low);
  endsequence

  key_fall_latch_a: assert property (key_fall_s |=> key_pend)
    else $error("keyboard fall did not latch a request");

  key_edge_only_a: assert property (
    !key_ctrl_reg.mode && !key_pend && !$rose(key_low) |=> !key_pend)
    else $error("edge-only keyboard latched without a fall");

  key_ack_clears_a: assert property (
    key_pend && !key_ctrl_reg.mode && key_ack && !$rose(key_low) |=> !key_pend)
    else $error("keyboard acknowledge did not clear edge request");

  second_level_holds_a: assert property (
    second_ctrl_reg.mode && !second_pin_n |=> second_pend)
    else $error("second pin low level did not hold request");

  // Latches see the pins two edges late; fewer stages would risk metastable reads
  key_sync_delay_a: assert property (
    !$past(RESET, 2) |-> key_pins_n == $past(KEY_PINS_N, 2))
    else $error("keyboard pins not delayed by two flops");

  first_sync_delay_a: assert property (
    !$past(RESET, 2) |-> first_pin_n == $past(FIRST_EXT_INT_PIN_N, 2))
    else $error("first pin not delayed by two flops");

endmodule : ext_pin_interrupts

// ==== logic/key_request_latch.sv ====
// Keyboard request latch: any-enabled-pin-low detect with two-step clear
`timescale 1ns/1ps
module key_request_latch
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [KEY_PINS-1:0] pins_n,
  input wire logic [KEY_PINS-1:0] enables,
  input wire logic mode,
  input wire logic ack,
  output logic pending
);
  logic any_low_prev_reg;
  logic ack_seen_reg;
  logic pending_reg;
  logic pending_next;
  logic ack_seen_next;
  wire logic any_low = |(~pins_n & enables);
  // Only a change from all-high to some-low counts as an edge
  wire logic fall = any_low & ~any_low_prev_reg;
  wire logic ack_any = ack | ack_seen_reg;
  assign pending_next = fall | (mode & any_low) | (pending_reg & ~ack_any);
  // Remember an early acknowledge until the pins come back high
  assign ack_seen_next = pending_next & ~fall & ack_any;
  assign pending = pending_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      any_low_prev_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      any_low_prev_reg <= any_low;
      ack_seen_reg <= ack_seen_next;
      pending_reg <= pending_next;
    end
  end
endmodule : key_request_latch

// ==== logic/pin_request_latch.sv ====
// Request latch for one active-low interrupt pin with edge or edge-and-level sense
`timescale 1ns/1ps
module pin_request_latch
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_n,
  input wire logic mode,
  input wire logic ack,
  output logic pending
);
  logic prev_reg;
  logic pending_reg;
  logic pending_next;
  wire logic fall = prev_reg & ~pin_n;
  // A new edge, or a held low level in edge-and-level mode, beats an acknowledge in the same cycle
  assign pending_next = fall | (mode & ~pin_n) | (pending_reg & ~ack);
  assign pending = pending_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_reg <= 1'b1;
      pending_reg <= 1'b0;
    end else begin
      prev_reg <= pin_n;
      pending_reg <= pending_next;
    end
  end
endmodule : pin_request_latch
